/* logic/async_serial_pkg.sv */
// Constants and types for the serial enable, stop and pin-routing block.
// Assumes a single peripheral clock and an AXI4-Lite register master.
package async_serial_pkg;
	// Printed offsets are register indexes; byte address is index times four
	localparam int          ADDR_W        = 18;
	localparam logic [15:0] IDX_PORT_DIR  = 16'hff2b;
	localparam logic [15:0] IDX_IN_SW     = 16'hff4f;
	localparam logic [15:0] IDX_MODE      = 16'hff50;
	localparam logic [15:0] IDX_RX_ERR    = 16'hff53;
	localparam logic [15:0] IDX_TX_STAT   = 16'hff54;
	localparam logic [15:0] IDX_TX_BUF    = 16'hff55;
	localparam logic [15:0] IDX_RX_BUF    = 16'hff52;
	localparam logic [15:0] IDX_BAUD      = 16'hff57;
	localparam logic [15:0] IDX_SER_CTRL  = 16'hff58;
	localparam logic [15:0] IDX_PORT_LAT  = 16'hff0b;
	localparam logic [15:0] IDX_SEG_SEL   = 16'hff5a;
	localparam logic [7:0]  PORT_DIR_RST  = 8'hff;
	localparam logic [7:0]  PORT_DIR_FIX  = 8'hf0;
	localparam logic [7:0]  IN_SW_RST     = 8'h00;
	localparam logic [7:0]  IN_SW_MASK    = 8'h0b;
	localparam logic [7:0]  MODE_RST      = 8'h01;
	localparam logic [7:0]  SER_CTRL_RST  = 8'h16;
	localparam logic [7:0]  SER_CTRL_MASK = 8'h3f;
	localparam logic [7:0]  BAUD_RST      = 8'hff;
	localparam logic [3:0]  PORT_LAT_RST  = 4'h0;
	localparam int          RX_GATE_BIT   = 3;
	localparam int          CAP_SEL_BIT   = 1;
	localparam int          IRQ_SEL_BIT   = 0;
	localparam int          BRK_FLAG_BIT  = 7;
	localparam int          BRK_TRIG_BIT  = 6;
	localparam int          ORDER_BIT     = 1;
	localparam int          INV_BIT       = 0;
	localparam int          TX_PIN        = 2;
	localparam int          RX_PIN        = 3;
	localparam logic [3:0]  DATA_BITS     = 4'h8;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef struct packed {
		logic unit_power;
		logic tx_enable;
		logic rx_enable;
		logic parity_sel_hi;
		logic parity_sel_lo;
		logic char_length;
		logic stop_length;
		logic rx_err_irq_mode;
	} mode_t;

	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_START = 4'b0010,
		S_DATA  = 4'b0100,
		S_STOP  = 4'b1000
	} line_state_t;
endpackage

/* logic/async_serial_ctrl.sv */
// Enable, stop and pin routing of the on-chip async serial unit, with a
// minimal full-duplex byte engine and an AXI4-Lite register slave.
// Assumes pins arrive unsynchronised; all pin drivers resolved outside.
// Function
// - Gate bit zero ignores receive pin
// - Capture select routes timer or receive pin
// - Interrupt select routes irq or receive pin
// - Input switch resets zero, bits 3,1,0 only
// - Direction bit zero enables output buffer
// - Direction resets all ones, top nibble ones
// - All enables off releases the tx pin unless the inversion bit is set; the rx pin is never driven
// - Mode register resets 01h, fixed layout
// - Power off stops and resets unit
// - Power off clears status, break, receive buffer
// - Transmit enable off resets transmit circuit
// - Receive enable off resets receive circuit
// - Power off holds tx and rx high
// - Full-duplex start-bit byte, own baud generator
// - Unused direction pin stays port pin
// - Inversion bit inverts transmit pin output
`timescale 1ns/100ps
`default_nettype none
module async_serial_ctrl
	import async_serial_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RSTN,
	input  wire logic [ADDR_W-1:0] AWADDR,
	input  wire logic              AWVALID,
	output var  logic              AWREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	input  wire logic              WVALID,
	output var  logic              WREADY,
	output var  logic [1:0]        BRESP,
	output var  logic              BVALID,
	input  wire logic              BREADY,
	input  wire logic [ADDR_W-1:0] ARADDR,
	input  wire logic              ARVALID,
	output var  logic              ARREADY,
	output var  logic [31:0]       RDATA,
	output var  logic [1:0]        RRESP,
	output var  logic              RVALID,
	input  wire logic              RREADY,
	input  wire logic [3:0]        PORT_IN,
	output var  logic [3:0]        PORT_OUT,
	output var  logic [3:0]        PORT_OE,
	input  wire logic              TIMER_PIN,
	input  wire logic              IRQ_PIN,
	output var  logic              TIMER_CAPTURE_IN,
	output var  logic              EXT_IRQ_ZERO,
	output var  logic              SEGMENT_SELECT
);
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction

	function automatic logic [7:0] reverse8(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			reverse8[i] = v[7-i];
		end
	endfunction

	function automatic logic [8:0] bit_len(input logic [7:0] k);
		bit_len = {k, 1'b0};
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [5:0] sync1_q, sync2_q, sync3_q, pin_q;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sync1_q <= 6'h3f;
			sync2_q <= 6'h3f;
			sync3_q <= 6'h3f;
			pin_q   <= 6'h3f;
		end else begin
			sync1_q <= {IRQ_PIN, TIMER_PIN, PORT_IN};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			for (int i = 0; i < 6; i++) begin
				if (sync2_q[i] == sync3_q[i]) begin
					pin_q[i] <= sync3_q[i];
				end
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	logic [3:0]  port_dir_q, port_lat_q;
	logic [7:0]  in_sw_q, ser_ctrl_q, baud_q, tx_buf_q, rx_buf_q;
	mode_t       mode_q;
	logic        seg_sel_q, brk_flag_q, tx_full_q, rx_full_q, overrun_q, frame_q;
	logic        aw_hold_q, w_hold_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [7:0]  w_data_q;
	logic        w_lane_q;
	logic        we, wr_tx, rd_rx, tx_load, rx_done, rx_state_frame_err;
	logic [7:0]  rx_data;

	assign we    = aw_hold_q & w_hold_q & ~BVALID & w_lane_q;
	assign wr_tx = we & hit(aw_addr_q, IDX_TX_BUF) & mode_q.unit_power & mode_q.tx_enable;
	assign rd_rx = ARVALID & ARREADY & hit(ARADDR, IDX_RX_BUF);

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			port_dir_q <= PORT_DIR_RST[3:0];
			in_sw_q    <= IN_SW_RST;
			mode_q     <= MODE_RST;
			ser_ctrl_q <= SER_CTRL_RST & SER_CTRL_MASK;
			baud_q     <= BAUD_RST;
			port_lat_q <= PORT_LAT_RST;
			seg_sel_q  <= 1'b0;
		end else if (we) begin
			if (hit(aw_addr_q, IDX_PORT_DIR)) begin
				port_dir_q <= w_data_q[3:0];
			end else if (hit(aw_addr_q, IDX_IN_SW)) begin
				in_sw_q <= w_data_q & IN_SW_MASK;
			end else if (hit(aw_addr_q, IDX_MODE)) begin
				mode_q <= w_data_q;
			end else if (hit(aw_addr_q, IDX_SER_CTRL)) begin
				ser_ctrl_q <= w_data_q & SER_CTRL_MASK;
			end else if (hit(aw_addr_q, IDX_BAUD)) begin
				baud_q <= w_data_q;
			end else if (hit(aw_addr_q, IDX_PORT_LAT)) begin
				port_lat_q <= w_data_q[3:0];
			end else if (hit(aw_addr_q, IDX_SEG_SEL)) begin
				seg_sel_q <= w_data_q[0];
			end
		end
	end

	// Break trigger never stores; writing it arms the break flag
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			brk_flag_q <= 1'b0;
		end else if (!mode_q.unit_power || !mode_q.rx_enable) begin
			brk_flag_q <= 1'b0;
		end else if (we && hit(aw_addr_q, IDX_SER_CTRL) && w_data_q[BRK_TRIG_BIT]) begin
			brk_flag_q <= 1'b1;
		end
	end

	// Status flags: a set in the same cycle as a clear wins
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			tx_full_q <= 1'b0;
			tx_buf_q  <= 8'h00;
			rx_full_q <= 1'b0;
			rx_buf_q  <= 8'h00;
			overrun_q <= 1'b0;
			frame_q   <= 1'b0;
		end else if (!mode_q.unit_power) begin
			tx_full_q <= 1'b0;
			rx_full_q <= 1'b0;
			rx_buf_q  <= 8'h00;
			overrun_q <= 1'b0;
			frame_q   <= 1'b0;
		end else begin
			if (wr_tx) begin
				tx_full_q <= 1'b1;
				tx_buf_q  <= w_data_q;
			end else if (tx_load || !mode_q.tx_enable) begin
				tx_full_q <= 1'b0;
			end
			if (rx_done) begin
				rx_full_q <= 1'b1;
				rx_buf_q  <= rx_data;
				overrun_q <= overrun_q | (rx_full_q & ~rd_rx);
			end else if (rd_rx) begin
				rx_full_q <= 1'b0;
			end
			if (rd_rx) begin
				frame_q   <= 1'b0;
				overrun_q <= 1'b0;
			end
			if (rx_state_frame_err) begin
				frame_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// Receive pin gating and routing
	// ****************************************
	logic rx_gated, rx_line;
	assign rx_gated = in_sw_q[RX_GATE_BIT] ? pin_q[RX_PIN] : 1'b1;
	assign rx_line  = mode_q.unit_power ? rx_gated : 1'b1;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			TIMER_CAPTURE_IN <= 1'b1;
			EXT_IRQ_ZERO     <= 1'b1;
			SEGMENT_SELECT   <= 1'b0;
		end else begin
			TIMER_CAPTURE_IN <= in_sw_q[CAP_SEL_BIT] ? rx_gated : pin_q[4];
			EXT_IRQ_ZERO     <= in_sw_q[IRQ_SEL_BIT] ? rx_gated : pin_q[5];
			SEGMENT_SELECT   <= seg_sel_q;
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	// Power off stands in for the gated clock and async reset of the unit:
	// the engine is cleared synchronously so no reset is ever driven by logic.
	line_state_t tx_state_q;
	logic [8:0]  tx_cnt_q;
	logic [7:0]  tx_sh_q;
	logic [3:0]  tx_bits_q;
	logic        tx_line_q, tx_run, tx_bit_end;
	assign tx_run     = mode_q.unit_power & mode_q.tx_enable;
	assign tx_bit_end = (tx_cnt_q == bit_len(baud_q) - 9'h001);
	assign tx_load    = tx_run & (tx_state_q == S_IDLE) & tx_full_q;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			tx_state_q <= S_IDLE;
			tx_cnt_q   <= 9'h000;
			tx_sh_q    <= 8'h00;
			tx_bits_q  <= 4'h0;
			tx_line_q  <= 1'b1;
		end else if (!tx_run) begin
			tx_state_q <= S_IDLE;
			tx_cnt_q   <= 9'h000;
			tx_bits_q  <= 4'h0;
			tx_line_q  <= 1'b1;
		end else begin
			tx_cnt_q <= (tx_bit_end || tx_state_q == S_IDLE) ? 9'h000 : tx_cnt_q + 9'h001;
			case (tx_state_q)
				S_IDLE: begin
					if (tx_full_q) begin
						tx_sh_q    <= ser_ctrl_q[ORDER_BIT] ? tx_buf_q : reverse8(tx_buf_q);
						tx_line_q  <= 1'b0;
						tx_state_q <= S_START;
					end
				end
				S_START: begin
					if (tx_bit_end) begin
						tx_line_q  <= tx_sh_q[0];
						tx_sh_q    <= {1'b0, tx_sh_q[7:1]};
						tx_bits_q  <= 4'h1;
						tx_state_q <= S_DATA;
					end
				end
				S_DATA: begin
					if (tx_bit_end) begin
						if (tx_bits_q == DATA_BITS) begin
							tx_line_q  <= 1'b1;
							tx_state_q <= S_STOP;
						end else begin
							tx_line_q <= tx_sh_q[0];
							tx_sh_q   <= {1'b0, tx_sh_q[7:1]};
							tx_bits_q <= tx_bits_q + 4'h1;
						end
					end
				end
				S_STOP: begin
					if (tx_bit_end) begin
						tx_state_q <= S_IDLE;
					end
				end
				default: tx_state_q <= S_IDLE;
			endcase
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	line_state_t rx_state_q;
	logic [8:0]  rx_cnt_q;
	logic [7:0]  rx_sh_q;
	logic [3:0]  rx_bits_q;
	logic        rx_run, rx_bit_end;
	assign rx_run     = mode_q.unit_power & mode_q.rx_enable;
	assign rx_bit_end = (rx_cnt_q == bit_len(baud_q) - 9'h001);
	assign rx_done    = rx_run & (rx_state_q == S_STOP) & rx_bit_end & rx_line;
	assign rx_state_frame_err = rx_run & (rx_state_q == S_STOP) & rx_bit_end & ~rx_line;
	assign rx_data    = ser_ctrl_q[ORDER_BIT] ? rx_sh_q : reverse8(rx_sh_q);

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rx_state_q <= S_IDLE;
			rx_cnt_q   <= 9'h000;
			rx_sh_q    <= 8'h00;
			rx_bits_q  <= 4'h0;
		end else if (!rx_run) begin
			rx_state_q <= S_IDLE;
			rx_cnt_q   <= 9'h000;
			rx_bits_q  <= 4'h0;
		end else begin
			rx_cnt_q <= (rx_bit_end || rx_state_q == S_IDLE) ? 9'h000 : rx_cnt_q + 9'h001;
			case (rx_state_q)
				S_IDLE: begin
					if (!rx_line) begin
						rx_state_q <= S_START;
					end
				end
				S_START: begin
					// Centre of the start bit; a glitch returns to idle
					if (rx_cnt_q == {1'b0, baud_q} - 9'h001) begin
						rx_cnt_q   <= 9'h000;
						rx_bits_q  <= 4'h0;
						rx_state_q <= rx_line ? S_IDLE : S_DATA;
					end
				end
				S_DATA: begin
					if (rx_bit_end) begin
						rx_sh_q   <= {rx_line, rx_sh_q[7:1]};
						rx_bits_q <= rx_bits_q + 4'h1;
						if (rx_bits_q == DATA_BITS - 4'h1) begin
							rx_state_q <= S_STOP;
						end
					end
				end
				S_STOP: begin
					if (rx_bit_end) begin
						rx_state_q <= S_IDLE;
					end
				end
				default: rx_state_q <= S_IDLE;
			endcase
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	logic tx_owns, inv;
	assign inv     = ser_ctrl_q[INV_BIT];
	assign tx_owns = (mode_q.unit_power & mode_q.tx_enable) | inv;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			PORT_OUT <= PORT_LAT_RST;
			PORT_OE  <= 4'h0;
		end else begin
			PORT_OE  <= ~port_dir_q;
			PORT_OUT <= port_lat_q;
			if (tx_owns) begin
				PORT_OUT[TX_PIN] <= tx_line_q ^ inv;
			end
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			AWREADY   <= 1'b0;
			WREADY    <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= 8'h00;
			w_lane_q  <= 1'b0;
			BVALID    <= 1'b0;
			BRESP     <= RESP_OKAY;
		end else begin
			AWREADY <= AWVALID & ~AWREADY & ~aw_hold_q;
			WREADY  <= WVALID & ~WREADY & ~w_hold_q;
			if (AWVALID && AWREADY) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_hold_q <= 1'b1;
				w_data_q <= WDATA[7:0];
				w_lane_q <= WSTRB[0];
			end
			if (aw_hold_q && w_hold_q && !BVALID) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				BVALID    <= 1'b1;
				BRESP     <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = hit(a, IDX_PORT_DIR) | hit(a, IDX_IN_SW) | hit(a, IDX_MODE)
			| hit(a, IDX_RX_ERR) | hit(a, IDX_TX_STAT) | hit(a, IDX_TX_BUF)
			| hit(a, IDX_RX_BUF) | hit(a, IDX_BAUD) | hit(a, IDX_SER_CTRL)
			| hit(a, IDX_PORT_LAT) | hit(a, IDX_SEG_SEL);
	endfunction

	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (hit(ARADDR, IDX_PORT_DIR)) begin
			rd_byte = PORT_DIR_FIX | {4'h0, port_dir_q};
		end else if (hit(ARADDR, IDX_IN_SW)) begin
			rd_byte = in_sw_q;
		end else if (hit(ARADDR, IDX_MODE)) begin
			rd_byte = mode_q;
		end else if (hit(ARADDR, IDX_RX_ERR)) begin
			rd_byte = {5'h00, frame_q, overrun_q, rx_full_q};
		end else if (hit(ARADDR, IDX_TX_STAT)) begin
			rd_byte = {6'h00, tx_full_q, tx_state_q != S_IDLE};
		end else if (hit(ARADDR, IDX_RX_BUF)) begin
			rd_byte = rx_buf_q;
		end else if (hit(ARADDR, IDX_BAUD)) begin
			rd_byte = baud_q;
		end else if (hit(ARADDR, IDX_SER_CTRL)) begin
			rd_byte = {brk_flag_q, 1'b0, ser_ctrl_q[5:0]};
		end else if (hit(ARADDR, IDX_PORT_LAT)) begin
			// Input-mode pins read the pin, output-mode pins the latch
			rd_byte = {4'h0, (port_dir_q & pin_q[3:0]) | (~port_dir_q & port_lat_q)};
		end else if (hit(ARADDR, IDX_SEG_SEL)) begin
			rd_byte = {7'h00, seg_sel_q};
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= 32'h0000_0000;
			RRESP   <= RESP_OKAY;
		end else begin
			ARREADY <= ARVALID & ~ARREADY & ~RVALID;
			if (ARVALID && ARREADY) begin
				RVALID <= 1'b1;
				RDATA  <= {24'h000000, rd_byte};
				RRESP  <= mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
			end else if (RVALID && RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/serial_node.sv */
// Remote serial node: 8 data bits, LSB first, one stop bit, no parity.
// Assumes the default bit_clks of 8 matches the bit time set by the baud divider.
`timescale 1ns/100ps
`default_nettype none
module serial_node (
	input  wire logic CLK,
	input  wire logic TX_LINE,
	output var  logic RX_LINE
);
	int bit_clks = 8;
	initial RX_LINE = 1'b1;
	// ****
	// Frames
	// ****
	// Start bit, one byte, stop bit, then an idle bit so the far end can settle
	task automatic send(input logic [7:0] b);
		RX_LINE <= 1'b0;
		repeat (bit_clks) @(posedge CLK);
		for (int i = 0; i < 8; i++) begin
			RX_LINE <= b[i];
			repeat (bit_clks) @(posedge CLK);
		end
		RX_LINE <= 1'b1;
		repeat (2 * bit_clks) @(posedge CLK);
	endtask
	task automatic hold_low(input int n);
		RX_LINE <= 1'b0;
		repeat (n) @(posedge CLK);
		RX_LINE <= 1'b1;
	endtask
	task automatic recv(output logic [7:0] b);
		@(negedge TX_LINE);
		repeat (bit_clks + bit_clks / 2) @(posedge CLK);
		for (int i = 0; i < 8; i++) begin
			b[i] = TX_LINE;
			repeat (bit_clks) @(posedge CLK);
		end
	endtask
endmodule
`default_nettype wire

/* testbench/async_serial_ctrl_chk.sv */
// Checker for the serial enable and pin-routing block.
// Sees only the top ports; bound at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module async_serial_ctrl_chk
	import async_serial_pkg::*;
(
	input wire logic              CLK,
	input wire logic              RSTN,
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic              AWVALID,
	input wire logic              AWREADY,
	input wire logic [31:0]       WDATA,
	input wire logic              WVALID,
	input wire logic              WREADY,
	input wire logic              BVALID,
	input wire logic              BREADY,
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic              ARVALID,
	input wire logic              ARREADY,
	input wire logic [31:0]       RDATA,
	input wire logic [1:0]        RRESP,
	input wire logic              RVALID,
	input wire logic              TIMER_PIN,
	input wire logic              IRQ_PIN,
	input wire logic              TIMER_CAPTURE_IN,
	input wire logic              EXT_IRQ_ZERO,
	input wire logic [3:0]        PORT_OE
);
	localparam logic [ADDR_W-1:0] A_SW = {IDX_IN_SW, 2'h0};
	localparam logic [ADDR_W-1:0] A_PD = {IDX_PORT_DIR, 2'h0};
	localparam logic [ADDR_W-1:0] A_MD = {IDX_MODE, 2'h0};
	logic [ADDR_W-1:0] aw_q;
	logic [ADDR_W-1:0] ar_q;
	logic [7:0]        wd_q;
	logic [7:0]        sw_q;
	logic [7:0]        pd_q;
	logic [7:0]        md_q;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// ****
	// Shadows
	// ****
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			aw_q <= '0;
			ar_q <= '0;
			wd_q <= '0;
		end else begin
			if (AWVALID && AWREADY) aw_q <= AWADDR;
			if (ARVALID && ARREADY) ar_q <= ARADDR;
			if (WVALID && WREADY) wd_q <= WDATA[7:0];
		end
	end
	// Lags the real register until the response is taken, so checks skip BVALID
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sw_q <= 8'h00;
			pd_q <= 8'hff;
			md_q <= 8'h01;
		end else if (BVALID && BREADY) begin
			if (aw_q == A_SW) sw_q <= wd_q & 8'h0b;
			if (aw_q == A_PD) pd_q <= wd_q | 8'hf0;
			if (aw_q == A_MD) md_q <= wd_q;
		end
	end
	// ****
	// Properties
	// ****
	isc_read_a: assert property ($rose(RVALID) && ar_q == A_SW |-> RDATA[7:0] == sw_q)
		else $error("input switch read mismatch");
	dir_read_a: assert property ($rose(RVALID) && ar_q == A_PD |-> RDATA[7:0] == pd_q)
		else $error("port direction read mismatch");
	mode_read_a: assert property ($rose(RVALID) && ar_q == A_MD |-> RDATA[7:0] == md_q)
		else $error("mode read mismatch");
	oe_dir_a: assert property ((!BVALID && $stable(pd_q))[*3] |-> PORT_OE == ~pd_q[3:0])
		else $error("output enable does not follow direction");
	route_tmr_a: assert property ((!sw_q[CAP_SEL_BIT] && $stable(TIMER_PIN) && !BVALID)[*7]
		|-> TIMER_CAPTURE_IN == TIMER_PIN) else $error("capture input not from timer pin");
	route_irq_a: assert property ((!sw_q[IRQ_SEL_BIT] && $stable(IRQ_PIN) && !BVALID)[*7]
		|-> EXT_IRQ_ZERO == IRQ_PIN) else $error("interrupt input not from irq pin");
	gate_off_a: assert property ((!sw_q[RX_GATE_BIT] && sw_q[CAP_SEL_BIT] && !BVALID)[*7]
		|-> TIMER_CAPTURE_IN) else $error("gated receive pin leaked through");
	bvalid_hold_a: assert property (BVALID && !BREADY |=> BVALID)
		else $error("write response dropped early");
	slverr_zero_a: assert property (RVALID && RRESP == RESP_SLVERR |-> RDATA == '0)
		else $error("refused read returned data");
	cover property ($rose(BVALID));
	cover property ($rose(RVALID) && RRESP == RESP_SLVERR);
	cover property (sw_q[CAP_SEL_BIT] && !TIMER_CAPTURE_IN);
endmodule
bind async_serial_ctrl async_serial_ctrl_chk u_async_serial_ctrl_chk (.*);
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the serial enable and pin-routing block.
// Assumes the node model on the serial pins; pin 2 has a pull-up.
`timescale 1ns/100ps
`default_nettype none
module tb
	import async_serial_pkg::*;
;
	logic              CLK = 1'b0;
	logic              RSTN = 1'b0;
	logic [ADDR_W-1:0] AWADDR = '0;
	logic [ADDR_W-1:0] ARADDR = '0;
	logic [31:0]       WDATA = '0;
	logic [3:0]        WSTRB = 4'hf;
	logic              AWVALID = 1'b0;
	logic              WVALID = 1'b0;
	logic              BREADY = 1'b0;
	logic              ARVALID = 1'b0;
	logic              RREADY = 1'b0;
	logic              AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0]        BRESP, RRESP;
	logic [31:0]       RDATA;
	logic [3:0]        PORT_IN, PORT_OUT, PORT_OE;
	logic [1:0]        pins_lo = 2'h2;
	logic              TIMER_PIN = 1'b1;
	logic              IRQ_PIN = 1'b1;
	logic              node_rx, TIMER_CAPTURE_IN, EXT_IRQ_ZERO, SEGMENT_SELECT;
	logic [7:0]        got;
	int                mismatches = 0;
	int                samples_checked = 0;
	always #25 CLK = ~CLK;
	// Wire level: the driving side wins, otherwise the outside source
	assign PORT_IN = (PORT_OE & PORT_OUT) | (~PORT_OE & {node_rx, 1'b1, pins_lo});
	async_serial_ctrl u_async_serial_ctrl (.*);
	serial_node u_serial_node (.CLK(CLK), .TX_LINE(PORT_OUT[TX_PIN]), .RX_LINE(node_rx));
	// ****
	// Bus and compare tasks
	// ****
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
		logic a;
		logic w;
		a = 1'b1;
		w = 1'b1;
		AWADDR <= {i, 2'h0};
		WDATA <= {24'h0, d};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		do begin
			@(posedge CLK);
			if (AWREADY) begin
				a = 1'b0;
				AWVALID <= 1'b0;
			end
			if (WREADY) begin
				w = 1'b0;
				WVALID <= 1'b0;
			end
		end while (a || w);
		BREADY <= 1'b1;
		do @(posedge CLK); while (!BVALID);
		BREADY <= 1'b0;
		chk(32'(BRESP), 32'(er));
	endtask
	task automatic rc(input logic [15:0] i, input logic [7:0] e, input logic [1:0] er = 2'h0);
		ARADDR <= {i, 2'h0};
		ARVALID <= 1'b1;
		do @(posedge CLK); while (!ARREADY);
		ARVALID <= 1'b0;
		RREADY <= 1'b1;
		do @(posedge CLK); while (!RVALID);
		RREADY <= 1'b0;
		chk(RDATA, {24'h0, e});
		chk(32'(RRESP), 32'(er));
	endtask
	task automatic do_reset;
		RSTN <= 1'b0;
		repeat (10) @(posedge CLK);
		RSTN <= 1'b1;
		@(posedge CLK);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset;
		rc(IDX_PORT_DIR, 8'hff);
		rc(IDX_IN_SW, 8'h00);
		rc(IDX_MODE, 8'h01);
		chk(32'(PORT_OE), 32'h0);
		$display("test reset values done");
	endtask
	task automatic t_regs;
		wr(IDX_IN_SW, 8'hff);
		rc(IDX_IN_SW, 8'h0b);
		wr(IDX_PORT_DIR, 8'h00);
		rc(IDX_PORT_DIR, 8'hf0);
		chk(32'(PORT_OE), 32'hf);
		wr(IDX_PORT_DIR, 8'h05);
		repeat (2) @(posedge CLK);
		chk(32'(PORT_OE), 32'ha);
		wr(16'h0000, 8'h55, RESP_SLVERR);
		rc(16'h0000, 8'h00, RESP_SLVERR);
		wr(IDX_PORT_DIR, 8'hff);
		wr(IDX_SEG_SEL, 8'h01);
		rc(IDX_SEG_SEL, 8'h01);
		chk(32'(SEGMENT_SELECT), 32'h1);
		wr(IDX_SEG_SEL, 8'h00);
		$display("test register access done");
	endtask
	task automatic t_route;
		wr(IDX_IN_SW, 8'h00);
		for (int k = 0; k < 4; k++) begin
			TIMER_PIN <= k[0];
			IRQ_PIN <= k[1];
			repeat (8) @(posedge CLK);
			chk(32'(TIMER_CAPTURE_IN), 32'(k[0]));
			chk(32'(EXT_IRQ_ZERO), 32'(k[1]));
		end
		TIMER_PIN <= 1'b0;
		IRQ_PIN <= 1'b0;
		wr(IDX_IN_SW, 8'h03);
		fork
			u_serial_node.hold_low(20);
			begin
				repeat (12) @(posedge CLK);
				chk(32'(TIMER_CAPTURE_IN), 32'h1);
				chk(32'(EXT_IRQ_ZERO), 32'h1);
			end
		join
		$display("test input routing done");
	endtask
	task automatic t_serial;
		wr(IDX_BAUD, 8'h04);
		wr(IDX_PORT_LAT, 8'h04);
		wr(IDX_PORT_DIR, 8'hfb);
		wr(IDX_IN_SW, 8'h0b);
		wr(IDX_MODE, 8'h80);
		wr(IDX_MODE, 8'he0);
		fork
			wr(IDX_TX_BUF, 8'ha5);
			u_serial_node.recv(got);
			u_serial_node.send(8'h3c);
		join
		chk(32'(got), 32'ha5);
		rc(IDX_RX_BUF, 8'h3c);
		// MSB first both ways; the node still shifts LSB first
		wr(IDX_SER_CTRL, 8'h14);
		fork
			wr(IDX_TX_BUF, 8'hc1);
			u_serial_node.recv(got);
			u_serial_node.send(8'h80);
			begin
				repeat (30) @(posedge CLK);
				chk(32'(TIMER_CAPTURE_IN), 32'h0);
				chk(32'(EXT_IRQ_ZERO), 32'h0);
			end
		join
		chk(32'(got), 32'h83);
		$display("test serial traffic done");
	endtask
	task automatic t_stop;
		rc(IDX_RX_ERR, 8'h01);
		wr(IDX_SER_CTRL, 8'h56);
		rc(IDX_SER_CTRL, 8'h96);
		wr(IDX_TX_BUF, 8'h55);
		repeat (20) @(posedge CLK);
		wr(IDX_MODE, 8'ha0);
		rc(IDX_TX_STAT, 8'h00);
		wr(IDX_PORT_LAT, 8'h00);
		@(posedge CLK);
		chk(32'(PORT_OUT[TX_PIN]), 32'h0);
		wr(IDX_MODE, 8'h80);
		wr(IDX_MODE, 8'h00);
		rc(IDX_RX_ERR, 8'h00);
		rc(IDX_RX_BUF, 8'h00);
		rc(IDX_SER_CTRL, 8'h16);
		wr(IDX_PORT_LAT, 8'h04);
		@(posedge CLK);
		chk(32'(PORT_OUT[TX_PIN]), 32'h1);
		wr(IDX_SER_CTRL, 8'h17);
		@(posedge CLK);
		chk(32'(PORT_OUT[TX_PIN]), 32'h0);
		$display("test stop sequence done");
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		do_reset;
		t_reset;
		t_regs;
		t_route;
		t_serial;
		t_stop;
		do_reset;
		t_reset;
		stop_test;
	end
	// Whole run is under a thousand cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge CLK);
		mismatches++;
		stop_test;
	end
endmodule
`default_nettype wire
